//--- prioritised_interrupt_control.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module prioritised_interrupt_control
(
    // clock, reset and freeze
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request sources
    input wire logic [irq_pkg::NUM_EXT-1:0] ext_pin,
    input wire logic [irq_pkg::NUM_SOURCES-1:0] periph_event,
    input wire logic [irq_pkg::NUM_TRAPS-1:0] trap_event,
    // cpu side
    output irq_pkg::irq_offer_type irq_offer,
    input wire logic irq_ack,
    input wire logic level_restore_valid,
    input wire logic [irq_pkg::LEVEL_W-1:0] level_restore,
    output logic [irq_pkg::LEVEL_W-1:0] cpu_priority_level,
    output logic alt_vector_table
);

    localparam int NS = irq_pkg::NUM_SOURCES;
    localparam int NT = irq_pkg::NUM_TRAPS;
    localparam int NE = irq_pkg::NUM_EXT;
    localparam int RW = irq_pkg::REG_W;

    logic [NS-1:0] flags, next_flags;
    logic [NS-1:0] enables, next_enables;
    logic [NS-1:0][irq_pkg::PRIO_W-1:0] prio, next_prio;
    logic nesting_disable, next_nesting_disable;
    logic [NT-1:0] trap_flags, next_trap_flags;
    logic next_alt_vector_table;
    logic [NE-1:0] ext_falling, next_ext_falling;
    logic [irq_pkg::LEVEL_W-1:0] next_cpu_priority_level;
    irq_pkg::irq_offer_type next_irq_offer;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [NE-1:0] ext_edge;
    logic [NS-1:0] set_event;
    logic [NS-1:0] eligible;
    logic nest_block;
    logic wr, setup;
    logic sel_ctrl_a, sel_ctrl_b, sel_flag, sel_enable, sel_prio, sel_status, sel_cpu, sel_core;
    logic rd_hit;
    logic [5:0] k;
    logic [RW-1:0] rd_word;
    logic best_valid, best_user;
    logic [irq_pkg::SRC_IDX_W-1:0] best_idx;
    logic [irq_pkg::LEVEL_W-1:0] best_lvl;
    logic [irq_pkg::VEC_W-1:0] best_vec;

    ////////////////////////////////////////////////////////////////////////////////
    ext_edge_detect #(.WIDTH(NE)) u_ext_edge
    (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .pin(ext_pin),
        .falling(ext_falling),
        .edge_pulse(ext_edge)
    );

    assign nest_block = nesting_disable && (cpu_priority_level != 4'h0);

    genvar g;
    generate
        for (g = 0; g < NS; g++)
        begin : gen_src
            if (g < NE)
            begin : gen_ext
                assign set_event[g] = periph_event[g] | ext_edge[g];
            end
            else
            begin : gen_int
                assign set_event[g] = periph_event[g];
            end
            assign eligible[g] = flags[g] & enables[g] & (prio[g] != 3'h0)
                & ({1'b0, prio[g]} > cpu_priority_level) & ~nest_block;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, pready only falls while frozen
    assign pready = ce;
    assign wr = psel && penable && pwrite && ce;
    assign setup = psel && !penable && ce;

    always_comb
    begin
        sel_ctrl_a = 1'b0;
        sel_ctrl_b = 1'b0;
        sel_flag = 1'b0;
        sel_enable = 1'b0;
        sel_prio = 1'b0;
        sel_status = 1'b0;
        sel_cpu = 1'b0;
        sel_core = 1'b0;
        k = 6'h00;
        if (paddr[1:0] != 2'h0)
            k = 6'h00;
        else if (paddr == irq_pkg::OFS_CTRL_A)
            sel_ctrl_a = 1'b1;
        else if (paddr == irq_pkg::OFS_CTRL_B)
            sel_ctrl_b = 1'b1;
        else if (paddr >= irq_pkg::OFS_FLAG0 && paddr < irq_pkg::OFS_ENABLE0)
        begin
            sel_flag = 1'b1;
            k = paddr[7:2] - irq_pkg::OFS_FLAG0[7:2];
        end
        else if (paddr >= irq_pkg::OFS_ENABLE0 && paddr < irq_pkg::OFS_PRIO0)
        begin
            sel_enable = 1'b1;
            k = paddr[7:2] - irq_pkg::OFS_ENABLE0[7:2];
        end
        else if (paddr >= irq_pkg::OFS_PRIO0 && paddr < irq_pkg::OFS_STATUS)
        begin
            sel_prio = 1'b1;
            k = paddr[7:2] - irq_pkg::OFS_PRIO0[7:2];
        end
        else if (paddr == irq_pkg::OFS_STATUS)
            sel_status = 1'b1;
        else if (paddr == irq_pkg::OFS_CPU_STATUS)
            sel_cpu = 1'b1;
        else if (paddr == irq_pkg::OFS_CORE_CONTROL)
            sel_core = 1'b1;
        rd_hit = sel_ctrl_a | sel_ctrl_b | sel_flag | sel_enable | sel_prio
            | sel_status | sel_cpu | sel_core;
    end

    always_comb
    begin
        rd_word = '0;
        if (sel_ctrl_a)
        begin
            rd_word[irq_pkg::NEST_DIS_BIT] = nesting_disable;
            rd_word[irq_pkg::TRAP_FLAG_LSB +: NT] = trap_flags;
        end
        else if (sel_ctrl_b)
        begin
            rd_word[irq_pkg::ALT_VECTOR_BIT] = alt_vector_table;
            rd_word[irq_pkg::EXT_POL_LSB +: NE] = ext_falling;
        end
        else if (sel_flag)
            rd_word = flags[int'(k) * RW +: RW];
        else if (sel_enable)
            rd_word = enables[int'(k) * RW +: RW];
        else if (sel_prio)
        begin
            // slots past the last source read as zero
            for (int j = 0; j < irq_pkg::PRIO_SLOTS; j++)
            begin
                if (int'(k) * irq_pkg::PRIO_SLOTS + j < NS)
                    rd_word[j * irq_pkg::PRIO_FIELD_STEP +: irq_pkg::PRIO_W] =
                        prio[int'(k) * irq_pkg::PRIO_SLOTS + j];
            end
        end
        else if (sel_status)
        begin
            rd_word[irq_pkg::STATUS_VEC_LSB +: irq_pkg::VEC_W] = irq_offer.vector;
            rd_word[irq_pkg::STATUS_LEVEL_LSB +: irq_pkg::LEVEL_W] = irq_offer.level;
        end
        else if (sel_cpu)
            rd_word[irq_pkg::CPU_LEVEL_LSB +: 3] = cpu_priority_level[2:0];
        else if (sel_core)
            rd_word[irq_pkg::CPU_TOP_BIT] = cpu_priority_level[3];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // arbitration: descending scan with >= lets the lower vector win a tie
    always_comb
    begin
        best_valid = 1'b0;
        best_user = 1'b0;
        best_idx = '0;
        best_lvl = '0;
        best_vec = '0;
        for (int i = NS - 1; i >= 0; i--)
        begin
            if (eligible[i] && {1'b0, prio[i]} >= best_lvl)
            begin
                best_valid = 1'b1;
                best_user = 1'b1;
                best_idx = irq_pkg::SRC_IDX_W'(i);
                best_lvl = {1'b0, prio[i]};
                best_vec = irq_pkg::FIRST_USER_VECTOR + 7'(i);
            end
        end
        // traps sit above every user level and ignore nesting disable
        for (int t = 0; t < NT; t++)
        begin
            if (trap_flags[t] && (irq_pkg::TRAP_BASE_LEVEL + 4'(t)) > cpu_priority_level)
            begin
                best_valid = 1'b1;
                best_user = 1'b0;
                best_lvl = irq_pkg::TRAP_BASE_LEVEL + 4'(t);
                best_vec = irq_pkg::TRAP_VECTOR_BASE + 7'(t);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_flags = flags;
        next_enables = enables;
        next_prio = prio;
        next_nesting_disable = nesting_disable;
        next_trap_flags = trap_flags;
        next_alt_vector_table = alt_vector_table;
        next_ext_falling = ext_falling;
        next_cpu_priority_level = cpu_priority_level;
        next_irq_offer = irq_offer;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (wr && sel_ctrl_a)
        begin
            next_nesting_disable = pwdata[irq_pkg::NEST_DIS_BIT];
            next_trap_flags = pwdata[irq_pkg::TRAP_FLAG_LSB +: NT];
        end
        if (wr && sel_ctrl_b)
        begin
            next_alt_vector_table = pwdata[irq_pkg::ALT_VECTOR_BIT];
            next_ext_falling = pwdata[irq_pkg::EXT_POL_LSB +: NE];
        end
        if (wr && sel_flag)
            next_flags[int'(k) * RW +: RW] = pwdata[RW-1:0];
        if (wr && sel_enable)
            next_enables[int'(k) * RW +: RW] = pwdata[RW-1:0];
        if (wr && sel_prio)
        begin
            for (int j = 0; j < irq_pkg::PRIO_SLOTS; j++)
            begin
                if (int'(k) * irq_pkg::PRIO_SLOTS + j < NS)
                    next_prio[int'(k) * irq_pkg::PRIO_SLOTS + j] =
                        pwdata[j * irq_pkg::PRIO_FIELD_STEP +: irq_pkg::PRIO_W];
            end
        end
        // an event in the cycle of a software clear still sets the flag
        if (ce)
        begin
            next_flags = next_flags | set_event;
            next_trap_flags = next_trap_flags | trap_event;
        end
        // ack beats restore beats a software write; the top bit is never software-written
        if (ce && irq_ack)
            next_cpu_priority_level = irq_offer.level;
        else if (ce && level_restore_valid)
            next_cpu_priority_level = level_restore;
        else if (wr && sel_cpu)
            next_cpu_priority_level[2:0] = pwdata[irq_pkg::CPU_LEVEL_LSB +: 3];
        if (ce)
        begin
            next_irq_offer.request = best_valid;
            if (best_valid)
            begin
                next_irq_offer.vector = best_vec;
                next_irq_offer.level = best_lvl;
            end
        end
        if (setup)
        begin
            next_prdata = {16'h0000, rd_word};
            next_pslverr = !rd_hit;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags <= '0;
            enables <= '0;
            prio <= {NS{irq_pkg::PRIO_RESET}};
            nesting_disable <= 1'b0;
            trap_flags <= '0;
            alt_vector_table <= 1'b0;
            ext_falling <= '0;
            cpu_priority_level <= irq_pkg::LEVEL_RESET;
            irq_offer <= '0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            flags <= next_flags;
            enables <= next_enables;
            prio <= next_prio;
            nesting_disable <= next_nesting_disable;
            trap_flags <= next_trap_flags;
            alt_vector_table <= next_alt_vector_table;
            ext_falling <= next_ext_falling;
            cpu_priority_level <= next_cpu_priority_level;
            irq_offer <= next_irq_offer;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_UNMAPPED_ERR: assert property (@(posedge clock) disable iff (!rst_n)
        setup && !rd_hit |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access without error");
    AST_NEST_BIT_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        wr && sel_ctrl_a |=> nesting_disable == $past(pwdata[irq_pkg::NEST_DIS_BIT]))
        else $error("nesting disable not written");
    AST_ALT_TABLE_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        wr && sel_ctrl_b |=> alt_vector_table == $past(pwdata[irq_pkg::ALT_VECTOR_BIT]))
        else $error("alternate table select not written");
    AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
        ce && (set_event[1] || (flags[1] && !(wr && sel_flag))) |=> flags[1])
        else $error("request flag lost");
    AST_ENABLE_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        best_valid && best_user |-> enables[best_idx] && flags[best_idx])
        else $error("disabled source requested");
    AST_PRIO_NONZERO: assert property (@(posedge clock) disable iff (!rst_n)
        best_valid && best_user |-> prio[best_idx] != 3'h0 && best_lvl < 4'h8)
        else $error("zero priority source requested");
    AST_STATUS_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
        ce && best_valid |=> irq_offer.request && irq_offer.vector == $past(best_vec)
        && irq_offer.level == $past(best_lvl))
        else $error("status did not latch pending vector");
    AST_LEVEL_IS_PRIO: assert property (@(posedge clock) disable iff (!rst_n)
        best_valid && best_user |-> best_lvl == {1'b0, prio[best_idx]})
        else $error("new level differs from source priority");
    AST_VECTOR_ORDER: assert property (@(posedge clock) disable iff (!rst_n)
        best_valid && best_user |-> best_vec == irq_pkg::FIRST_USER_VECTOR + 7'(best_idx))
        else $error("vector out of table order");
    AST_TOP_BIT_RO: assert property (@(posedge clock) disable iff (!rst_n)
        wr && (sel_core || sel_cpu) && !irq_ack && !level_restore_valid
        |=> $stable(cpu_priority_level[3]))
        else $error("software changed level top bit");
    AST_ABOVE_LEVEL: assert property (@(posedge clock) disable iff (!rst_n)
        best_valid |-> best_lvl > cpu_priority_level)
        else $error("request not above cpu level");
    AST_NEST_BLOCK: assert property (@(posedge clock) disable iff (!rst_n)
        ce && nesting_disable && cpu_priority_level != 4'h0 && trap_flags == '0
        |=> !irq_offer.request)
        else $error("nested request while nesting disabled");

endmodule

//--- irq_pkg.sv
package irq_pkg;

    // sizes
    localparam int NUM_SOURCES = 32;
    localparam int NUM_TRAPS = 4;
    localparam int NUM_EXT = 3;
    localparam int SRC_IDX_W = 5;
    localparam int REG_W = 16;
    localparam int PRIO_W = 3;
    localparam int PRIO_SLOTS = 4;
    localparam int LEVEL_W = 4;
    localparam int VEC_W = 7;

    // byte offsets of aligned words; FLAG0, ENABLE0 and PRIO0 each start a bank of several words
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_FLAG0 = 8'h08;
    localparam logic [7:0] OFS_ENABLE0 = 8'h10;
    localparam logic [7:0] OFS_PRIO0 = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h40;
    localparam logic [7:0] OFS_CPU_STATUS = 8'h44;
    localparam logic [7:0] OFS_CORE_CONTROL = 8'h48;

    // field positions
    localparam int NEST_DIS_BIT = 15;
    localparam int TRAP_FLAG_LSB = 1;
    localparam int ALT_VECTOR_BIT = 15;
    localparam int EXT_POL_LSB = 0;
    localparam int STATUS_VEC_LSB = 0;
    localparam int STATUS_LEVEL_LSB = 8;
    localparam int CPU_LEVEL_LSB = 5;
    localparam int CPU_TOP_BIT = 3;
    localparam int PRIO_FIELD_STEP = 4;

    // reset values
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;

    // vector and level assignment
    localparam logic [VEC_W-1:0] FIRST_USER_VECTOR = 7'h08;
    localparam logic [VEC_W-1:0] TRAP_VECTOR_BASE = 7'h01;
    localparam logic [LEVEL_W-1:0] TRAP_BASE_LEVEL = 4'h8;

    typedef struct packed {
        logic request;
        logic [VEC_W-1:0] vector;
        logic [LEVEL_W-1:0] level;
    } irq_offer_type;

endpackage

//--- ext_edge_detect.sv
`timescale 1ns/100ps
module ext_edge_detect
#(
    parameter int WIDTH = 3
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // pins and selection
    input wire logic [WIDTH-1:0] pin,
    input wire logic [WIDTH-1:0] falling,
    // detected edges
    output logic [WIDTH-1:0] edge_pulse
);

    logic [WIDTH-1:0] meta, next_meta;
    logic [WIDTH-1:0] stable, next_stable;
    logic [WIDTH-1:0] prev, next_prev;
    logic [2:0] fill, next_fill;

    always_comb
    begin
        next_meta = ce ? pin : meta;
        next_stable = ce ? meta : stable;
        next_prev = ce ? stable : prev;
        next_fill = ce ? {fill[1:0], 1'b1} : fill;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
            fill <= 3'h0;
        end
        else
        begin
            meta <= next_meta;
            stable <= next_stable;
            prev <= next_prev;
            fill <= next_fill;
        end
    end

    // only the second and third stages are compared; the first may be metastable
    // no edge until both compared stages hold real samples, so a pin idling high
    // does not look like a rising edge right after reset
    assign edge_pulse = (ce && fill[2])
        ? ((falling & prev & ~stable) | (~falling & ~prev & stable)) : '0;

endmodule

//--- cpu_model.sv
`timescale 1ns/100ps
// cpu stand-in: takes the offer after a chosen wait, returns to level 0 after a hold
module cpu_model
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bench control
    input wire logic en,
    input wire logic [3:0] ack_wait,
    input wire logic [7:0] hold,
    // controller side
    input wire irq_pkg::irq_offer_type irq_offer,
    output logic irq_ack,
    output logic level_restore_valid,
    output logic [irq_pkg::LEVEL_W-1:0] level_restore
);
    int cnt;
    logic busy;
    ////////////////////////////////////////////////////////////////////////////////////////////
    // restore data toggles outside its strobe so a stale value is never mistaken for a good one
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_ack <= 1'b0;
            level_restore_valid <= 1'b0;
            level_restore <= 4'h5;
            busy <= 1'b0;
            cnt <= 0;
        end
        else
        begin
            irq_ack <= 1'b0;
            level_restore_valid <= 1'b0;
            level_restore <= ~level_restore;
            if (!busy && en && irq_offer.request)
            begin
                cnt <= (cnt == int'(ack_wait)) ? 0 : cnt + 1;
                irq_ack <= (cnt == int'(ack_wait));
                busy <= (cnt == int'(ack_wait));
            end
            else if (busy)
            begin
                cnt <= (cnt == int'(hold)) ? 0 : cnt + 1;
                busy <= (cnt != int'(hold));
                level_restore_valid <= (cnt == int'(hold));
                level_restore <= (cnt == int'(hold)) ? 4'h0 : ~level_restore;
            end
            else
            begin
                cnt <= 0;
            end
        end
    end
endmodule

//--- tb.sv
`timescale 1ns/100ps
module tb;
    logic clock, rst_n, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata, rnd, periph_event;
    logic [2:0] ext_pin;
    logic [3:0] trap_event, level_restore, cpu_priority_level, m_wait;
    irq_pkg::irq_offer_type irq_offer;
    logic irq_ack, level_restore_valid, alt_vector_table, m_en;
    logic [7:0] m_hold;
    int bad_count, checks, i, n;
    logic [2:0] p;
    logic [7:0] fa, ea, pa;
    logic [31:0] bitm;

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

    prioritised_interrupt_control dut (.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin), .periph_event(periph_event),
        .trap_event(trap_event), .irq_offer(irq_offer), .irq_ack(irq_ack),
        .level_restore_valid(level_restore_valid), .level_restore(level_restore),
        .cpu_priority_level(cpu_priority_level), .alt_vector_table(alt_vector_table));
    cpu_model cpu (.clock(clock), .rst_n(rst_n), .en(m_en), .ack_wait(m_wait), .hold(m_hold),
        .irq_offer(irq_offer), .irq_ack(irq_ack), .level_restore_valid(level_restore_valid),
        .level_restore(level_restore));

    always #20 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [31:0] prio_word(input int slot, input logic [2:0] pv);
        logic [31:0] w;
        w = 32'h0000_4444;
        w[4*slot+:3] = pv;
        return w;
    endfunction
    function automatic logic [11:0] exp_offer(input int src, input logic [3:0] lvl);
        return {1'b1, 7'(8 + src), lvl};
    endfunction
    function automatic logic [31:0] status_word(input logic [11:0] e);
        return {20'h0, e[3:0], 1'b0, e[10:4]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    // the master waits on pready itself; only the watchdog cuts a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask
    task automatic pulse(input logic [31:0] pe, input logic [3:0] te);
        @(posedge clock);
        periph_event <= pe;
        trap_event <= te;
        @(posedge clock);
        periph_event <= 32'h0;
        trap_event <= 4'h0;
    endtask
    // vector and level only hold meaning while request is up
    task automatic offer_chk(input logic [11:0] e);
        settle(3);
        if (e[11])
            `CHK(irq_offer, e)
        else
            `CHK(irq_offer.request, 1'b0)
    endtask
    task automatic wait_level(input logic [3:0] l);
        n = 0;
        while (cpu_priority_level !== l && n < 100)
        begin
            settle(1);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        final_report();
    end
    initial
    begin
        {clock, rst_n, psel, penable, pwrite, m_en} = 6'h0;
        {paddr, pwdata, periph_event, ext_pin, trap_event} = '0;
        {ce, m_wait, m_hold, bad_count, checks, rnd} = {1'b1, 4'h0, 8'h28, 64'h0, 32'hcb90};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h18, 32'h4444);
        rd_chk(8'h3c, 32'h0);
        wr(8'h40, 32'hffff);
        rd_chk(8'h40, 32'h0);
        rd_chk(8'h4c, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h02, 32'h0);
        `CHK(err, 1'b1)
        $display("test registers done");
        wr(8'h10, 32'h28);
        pulse(32'h28, 4'h0);
        offer_chk(exp_offer(3, 4'h4));
        rd_chk(8'h08, 32'h28);
        wr(8'h1c, prio_word(1, 3'h6));
        offer_chk(exp_offer(5, 4'h6));
        wr(8'h44, 32'hc0);
        offer_chk(12'h0);
        `CHK(cpu_priority_level, 4'h6)
        rd_chk(8'h48, 32'h0);
        wr(8'h44, 32'h60);
        offer_chk(exp_offer(5, 4'h6));
        wr(8'h00, 32'h8000);
        offer_chk(12'h0);
        pulse(32'h0, 4'h4);
        offer_chk({1'b1, 7'h03, 4'ha});
        rd_chk(8'h00, 32'h8008);
        wr(8'h00, 32'h0);
        offer_chk(exp_offer(5, 4'h6));
        wr(8'h44, 32'h0);
        wr(8'h08, 32'h0);
        offer_chk(12'h0);
        wr(8'h10, 32'h0);
        wr(8'h1c, 32'h4444);
        $display("test arbitration done");
        for (int k = 0; k < 8; k++)
        begin
            rnd = xs(rnd);
            i = (k == 0) ? 0 : (k == 1) ? 31 : int'(rnd[4:0]);
            p = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : rnd[10:8];
            fa = (i < 16) ? 8'h08 : 8'h0c;
            ea = fa + 8'h08;
            pa = 8'h18 + 8'(4 * (i / 4));
            bitm = 32'h1 << (i % 16);
            wr(pa, prio_word(i % 4, p));
            pulse(32'h1 << i, 4'h0);
            offer_chk(12'h0);
            rd_chk(fa, bitm);
            wr(ea, bitm);
            offer_chk((p == 3'h0) ? 12'h0 : exp_offer(i, {1'b0, p}));
            if (p != 3'h0)
                rd_chk(8'h40, status_word(exp_offer(i, {1'b0, p})));
            wr(fa, 32'h0);
            offer_chk(12'h0);
            wr(ea, 32'h0);
            wr(pa, 32'h4444);
        end
        $display("test random sources done");
        @(posedge clock);
        ext_pin <= 3'b001;
        settle(8);
        rd_chk(8'h08, 32'h1);
        wr(8'h04, 32'h8002);
        settle(1);
        `CHK(alt_vector_table, 1'b1)
        rd_chk(8'h04, 32'h8002);
        ext_pin <= 3'b011;
        settle(8);
        rd_chk(8'h08, 32'h1);
        ext_pin <= 3'b001;
        settle(8);
        rd_chk(8'h08, 32'h3);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h0);
        settle(1);
        `CHK(alt_vector_table, 1'b0)
        $display("test external pins done");
        @(posedge clock);
        ce <= 1'b0;
        settle(1);
        `CHK(pready, 1'b0)
        pulse(32'h4, 4'h4);
        ce <= 1'b1;
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h00, 32'h0);
        $display("test freeze done");
        for (int w = 0; w < 2; w++)
        begin
            m_wait <= 4'(3 * w);
            m_en <= 1'b1;
            wr(8'h10, 32'h1);
            pulse(32'h1, 4'h0);
            wait_level(4'h4);
            `CHK(cpu_priority_level, 4'h4)
            offer_chk(12'h0);
            rd_chk(8'h40, 32'h0408);
            wr(8'h08, 32'h0);
            wait_level(4'h0);
            `CHK(cpu_priority_level, 4'h0)
            m_en <= 1'b0;
            wr(8'h10, 32'h0);
        end
        $display("test cpu handshake done");
        final_report();
    end
endmodule
